//--- hw/capture_if.sv
// Interface: sample word passed from the capture block to the sequencer.
// Assumes one clock shared by both ends.
`timescale 1ns/1ps
interface capture_if;
	logic valid;
	logic [14:0] word;
	modport source
	(
		output valid,
		output word
	);
	modport sink
	(
		input valid,
		input word
	);
endinterface

//--- hw/ccd_convert_ctrl.sv
// Controller for a CCD correlated-double-sampling converter: drives bandwidth select,
// reference hold and start convert, captures results, and is programmed over APB.
// Assumes data pins are asynchronous to clk and data-valid rises once per conversion.
//
// Summary of operation
// - Bandwidth-select pins are held static from a control register field.
// - Start edges are spaced at least the selected setting's conversion period.
// - Hold rises only after a programmable reference settle time.
// - Each conversion begins with exactly one start-convert rising edge.
// - Hold falls only after the start-convert rising edge.
// - Hold falls within the reference quiet time, shortly after the start edge.
// - Flag with high MSB means overrange, with low MSB underrange.
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
module ccd_convert_ctrl
	import ccd_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic bandwidth_select_bit0,
	output logic bandwidth_select_bit1,
	output logic reference_hold,
	output logic start_convert,
	input wire logic [13:0] data_pin,
	input wire logic out_of_range_pin,
	input wire logic data_valid_pin,
	output logic irq
);
	capture_if cap ();

	logic [5:0] ctrl_r;
	logic [15:0] period_r;
	logic [15:0] hold_r;
	logic [irq_width-1:0] irq_status_r;
	logic [irq_width-1:0] irq_mask_r;
	logic [14:0] sample_r;
	logic [15:0] count_r;
	logic [15:0] timer_r;
	logic [15:0] gap_r;
	logic busy_r;
	logic single_r;
	seq_state_t state_r;
	seq_state_t state_nxt;
	logic [15:0] min_period;
	logic [15:0] eff_period;
	logic wr_en;
	logic rd_en;
	logic start_req;
	logic [irq_width-1:0] irq_set;
	logic over_evt;
	logic under_evt;

	sample_capture u_capture
	(
		.clk(clk),
		.reset(reset),
		.data_pin(data_pin),
		.out_of_range_pin(out_of_range_pin),
		.data_valid_pin(data_valid_pin),
		.cap(cap)
	);

	////////////////////////////////////////////////////////////////////////
	// APB slave: zero wait states, unmapped addresses answer with pslverr
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !penable && !pwrite;

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ctrl_r <= 6'h00;
			period_r <= period_default;
			hold_r <= hold_default;
			irq_mask_r <= '0;
		end
		else if (wr_en)
		begin
			case (paddr)
				addr_ctrl: ctrl_r <= pwdata[5:0];
				addr_period: period_r <= pwdata[15:0];
				addr_hold: hold_r <= pwdata[15:0];
				addr_irq_mask: irq_mask_r <= pwdata[irq_width-1:0];
				default: ;
			endcase
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable)
			begin
				case (paddr)
					addr_ctrl, addr_period, addr_hold, addr_status, addr_irq_status,
					addr_irq_mask, addr_sample, addr_count: pslverr <= 1'b0;
					default: pslverr <= 1'b1;
				endcase
			end
			if (rd_en)
			begin
				case (paddr)
					addr_ctrl: prdata <= {26'h0, ctrl_r};
					addr_period: prdata <= {16'h0, period_r};
					addr_hold: prdata <= {16'h0, hold_r};
					addr_status: prdata <= {28'h0, busy_r, state_r};
					addr_irq_status: prdata <= {28'h0, irq_status_r};
					addr_irq_mask: prdata <= {28'h0, irq_mask_r};
					addr_sample: prdata <= {17'h0, sample_r};
					addr_count: prdata <= {16'h0, count_r};
					default: prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Bandwidth pins change only while idle so they stay static in a frame
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			bandwidth_select_bit0 <= 1'b0;
			bandwidth_select_bit1 <= 1'b0;
		end
		else if (state_r == st_idle)
		begin
			bandwidth_select_bit0 <= ctrl_r[ctrl_bw_lo];
			bandwidth_select_bit1 <= ctrl_r[ctrl_bw_hi];
		end
	end

	always_comb
	begin
		case ({bandwidth_select_bit1, bandwidth_select_bit0})
			2'b00: min_period = period_bw0_cyc;
			2'b01: min_period = period_bw1_cyc;
			2'b10: min_period = period_bw2_cyc;
			default: min_period = period_bw3_cyc;
		endcase
		// Software may slow the rate but never beat the setting's limit
		eff_period = (period_r > min_period) ? period_r : min_period;
	end

	assign start_req = (ctrl_r[ctrl_enable_bit] || single_r) && gap_r >= eff_period - 16'h0001;

	////////////////////////////////////////////////////////////////////////
	// Pixel sequencer
	always_comb
	begin
		state_nxt = state_r;
		case (state_r)
			st_idle: if (ctrl_r[ctrl_enable_bit] || single_r) state_nxt = st_settle;
			st_settle: if (timer_r == 16'h0000) state_nxt = st_hold;
			st_hold: if (start_req) state_nxt = st_start;
			st_start: state_nxt = st_release;
			st_release: if (timer_r == 16'h0000) state_nxt = st_wait;
			st_wait: state_nxt = (ctrl_r[ctrl_enable_bit] || single_r) ? st_settle : st_idle;
			default: state_nxt = st_idle;
		endcase
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			state_r <= st_idle;
		else
			state_r <= state_nxt;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			timer_r <= 16'h0000;
		else if (state_r == st_idle || (state_r == st_wait))
			timer_r <= hold_r;
		else if (state_r == st_start)
			timer_r <= release_cyc;
		else if (timer_r != 16'h0000)
			timer_r <= timer_r - 16'h0001;
	end

	// Counts up since the last start, so a slower setting chosen later still spaces it
	always_ff @(posedge clk)
	begin
		if (reset)
			gap_r <= 16'hffff;
		else if (state_r == st_start)
			gap_r <= 16'h0001;
		else if (gap_r != 16'hffff)
			gap_r <= gap_r + 16'h0001;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			reference_hold <= 1'b0;
			start_convert <= 1'b0;
		end
		else
		begin
			// Hold high from settle done until the release delay after start
			reference_hold <= (state_nxt == st_hold) || (state_nxt == st_start)
				|| (state_nxt == st_release);
			start_convert <= (state_nxt == st_start); // One edge per pixel
		end
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			single_r <= 1'b0;
		else if (wr_en && paddr == addr_ctrl && pwdata[ctrl_single_bit])
			single_r <= 1'b1;
		else if (state_r == st_start)
			single_r <= 1'b0;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
			busy_r <= 1'b0;
		else if (state_r == st_start)
			busy_r <= 1'b1;
		else if (cap.valid)
			busy_r <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	// Results and interrupts
	assign over_evt = cap.valid && cap.word[range_bit] && cap.word[data_width-1];
	assign under_evt = cap.valid && cap.word[range_bit] && !cap.word[data_width-1];

	always_comb
	begin
		irq_set = '0;
		irq_set[irq_sample_bit] = cap.valid;
		irq_set[irq_over_bit] = over_evt;
		irq_set[irq_under_bit] = under_evt;
		// A new result captured while the previous result's flag is still uncleared by software
		irq_set[irq_lost_bit] = cap.valid && irq_status_r[irq_sample_bit];
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			sample_r <= 15'h0000;
			count_r <= 16'h0000;
		end
		else if (cap.valid)
		begin
			sample_r <= cap.word;
			count_r <= count_r + 16'h0001;
		end
	end

	genvar i;
	generate
		for (i = 0; i < irq_width; i++)
		begin : g_irq
			always_ff @(posedge clk)
			begin
				if (reset)
					irq_status_r[i] <= 1'b0;
				else if (irq_set[i])
					irq_status_r[i] <= 1'b1;
				else if (wr_en && paddr == addr_irq_status && pwdata[i])
					irq_status_r[i] <= 1'b0;
			end
		end
	endgenerate

	always_ff @(posedge clk)
	begin
		if (reset)
			irq <= 1'b0;
		else
			irq <= |(irq_status_r & irq_mask_r);
	end
endmodule

//--- hw/ccd_ctrl_pkg.sv
// Package: register map, pin timing and field layouts for the CCD converter controller.
// Assumes a 125 MHz clock and an APB slave with 32-bit data.
package ccd_ctrl_pkg;
	localparam int unsigned clk_period_ps = 8000;
	localparam logic [7:0] addr_ctrl = 8'h00;
	localparam logic [7:0] addr_period = 8'h04;
	localparam logic [7:0] addr_hold = 8'h08;
	localparam logic [7:0] addr_status = 8'h0c;
	localparam logic [7:0] addr_irq_status = 8'h10;
	localparam logic [7:0] addr_irq_mask = 8'h14;
	localparam logic [7:0] addr_sample = 8'h18;
	localparam logic [7:0] addr_count = 8'h1c;
	localparam int ctrl_enable_bit = 0;
	localparam int ctrl_single_bit = 1;
	localparam int ctrl_bw_lo = 4;
	localparam int ctrl_bw_hi = 5;
	localparam int data_width = 14;
	localparam int range_bit = 14;
	localparam int irq_sample_bit = 0;
	localparam int irq_over_bit = 1;
	localparam int irq_under_bit = 2;
	localparam int irq_lost_bit = 3;
	localparam int irq_width = 4;
	// Least conversion period for each bandwidth setting, in ns
	localparam int unsigned period_bw0_ns = 200;
	localparam int unsigned period_bw1_ns = 334;
	localparam int unsigned period_bw2_ns = 500;
	localparam int unsigned period_bw3_ns = 1000;
	// Least time from the start edge to releasing the hold, in ns
	localparam int unsigned release_ns = 16;
	localparam int unsigned ns_ps = 1000;
	localparam int cnt_width = 16;
	localparam logic [15:0] period_bw0_cyc = 16'((period_bw0_ns * ns_ps + clk_period_ps - 1) / clk_period_ps);
	localparam logic [15:0] period_bw1_cyc = 16'((period_bw1_ns * ns_ps + clk_period_ps - 1) / clk_period_ps);
	localparam logic [15:0] period_bw2_cyc = 16'((period_bw2_ns * ns_ps + clk_period_ps - 1) / clk_period_ps);
	localparam logic [15:0] period_bw3_cyc = 16'((period_bw3_ns * ns_ps + clk_period_ps - 1) / clk_period_ps);
	localparam logic [15:0] release_cyc = 16'((release_ns * ns_ps + clk_period_ps - 1) / clk_period_ps);
	localparam logic [15:0] hold_default = 16'h0004;
	localparam logic [15:0] period_default = 16'h0000;
	typedef enum logic [2:0]
	{
		st_idle = 3'b000,
		st_settle = 3'b001,
		st_hold = 3'b010,
		st_start = 3'b011,
		st_release = 3'b100,
		st_wait = 3'b101
	} seq_state_t;
endpackage

//--- hw/sample_capture.sv
// Synchronises the converter's data pins and catches a sample on each data-valid rise.
// Assumes the data pins are stable around the data-valid rising edge.
`timescale 1ns/1ps
module sample_capture
	import ccd_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [13:0] data_pin,
	input wire logic out_of_range_pin,
	input wire logic data_valid_pin,
	capture_if.source cap
);
	logic [14:0] word_meta_r;
	logic [14:0] word_sync_r;
	logic [14:0] word_dly_r;
	logic valid_meta_r;
	logic valid_sync_r;
	logic valid_dly_r;

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk)
	begin
		word_meta_r <= {out_of_range_pin, data_pin};
		word_sync_r <= word_meta_r;
		// Extra stage so the word is one cycle older than the valid edge
		word_dly_r <= word_sync_r;
	end

	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			valid_meta_r <= 1'b0;
			valid_sync_r <= 1'b0;
			valid_dly_r <= 1'b0;
		end
		else
		begin
			valid_meta_r <= data_valid_pin;
			valid_sync_r <= valid_meta_r;
			valid_dly_r <= valid_sync_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			cap.valid <= 1'b0;
			cap.word <= 15'h0000;
		end
		else
		begin
			cap.valid <= valid_sync_r && !valid_dly_r;
			if (valid_sync_r && !valid_dly_r)
				cap.word <= word_dly_r; // Flag and data taken as one word
		end
	end
endmodule

//--- verification/ccd_convert_ctrl_bench.sv
// Bench: APB sequences program conversions and check results.
// Assumes the device model answers each start within a dozen cycles.
`timescale 1ns/1ps
module ccd_convert_ctrl_bench;
	import ccd_ctrl_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic signed [15:0] diff = 16'sh0000;
	logic [31:0] prdata, rdata;
	logic pready, pslverr, b0, b1, hold, start, irq, oor, dval, err;
	logic [13:0] data_pin;
	int fails = 0;
	int checks_done = 0;
	logic [15:0] diffs [4] = '{16'h0064, 16'h4e20, 16'hfffb, 16'h2000};
	logic [31:0] exp_s [4] = '{32'h64, 32'h7fff, 32'h4000, 32'h2000};
	logic [31:0] exp_i [4] = '{32'h1, 32'h3, 32'h5, 32'h1};
	initial
		forever #4 clk = ~clk;
	ccd_convert_ctrl u_dut (.clk(clk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bandwidth_select_bit0(b0), .bandwidth_select_bit1(b1), .reference_hold(hold),
		.start_convert(start), .data_pin(data_pin), .out_of_range_pin(oor), .data_valid_pin(dval), .irq(irq));
	ccd_device_model u_dev (.clk(clk), .reference_hold(hold), .start_convert(start), .diff(diff),
		.data_pin(data_pin), .out_of_range_pin(oor), .data_valid_pin(dval));
	////////////////////////////////////////
	task automatic print_verdict();
		$display("checks_done=%0d fails=%0d", checks_done, fails);
		if (fails == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic timeout();
		fails++;
		print_verdict();
	endtask
	task automatic cmp32(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp)
		begin
			fails++;
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		@(posedge clk);
		psel <= 1'b1;
		paddr <= a;
		pwrite <= w;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (pready !== 1'b1 && n < 20);
		if (pready !== 1'b1)
			timeout();
		rdata = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] e);
		apb(a, 1'b0, 32'h0);
		cmp32(rdata, e);
	endtask
	task automatic wait_sample();
		int n;
		n = 0;
		do
		begin
			apb(addr_irq_status, 1'b0, 32'h0);
			n++;
		end
		while (rdata[irq_sample_bit] !== 1'b1 && n < 60);
		if (rdata[irq_sample_bit] !== 1'b1)
			timeout();
	endtask
	////////////////////////////////////////
	initial
	begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		rdc(addr_ctrl, 32'h0);
		rdc(addr_hold, 32'h4);
		rdc(addr_period, 32'h0);
		rdc(addr_count, 32'h0);
		rdc(8'h20, 32'h0);
		cmp32({31'h0, err}, 32'h1);
		$display("test reset_values done");
		// Slowest first, so each new minimum gap is shorter
		apb(addr_irq_mask, 1'b1, 32'h1);
		for (int i = 0; i < 4; i++)
		begin
			diff <= diffs[i];
			apb(addr_ctrl, 1'b1, 32'((3 - i) << ctrl_bw_lo) | 32'h2);
			wait_sample();
			cmp32({30'h0, b1, b0}, 32'(3 - i));
			cmp32({31'h0, irq}, 32'h1);
			rdc(addr_sample, exp_s[i]);
			rdc(addr_irq_status, exp_i[i]);
			apb(addr_irq_status, 1'b1, 32'hf);
			rdc(addr_irq_status, 32'h0);
			cmp32({31'h0, irq}, 32'h0);
		end
		$display("test single_conversions done");
		apb(addr_irq_mask, 1'b1, 32'h0);
		diff <= 16'sh0000;
		apb(addr_ctrl, 1'b1, 32'h2);
		wait_sample();
		cmp32({31'h0, irq}, 32'h0);
		rdc(addr_sample, 32'h0);
		rdc(addr_count, 32'h5);
		rdc(addr_status, 32'h0);
		apb(addr_irq_status, 1'b1, 32'hf);
		$display("test masked_zero done");
		apb(addr_period, 1'b1, 32'h28);
		apb(addr_ctrl, 1'b1, 32'h1);
		repeat (400) @(posedge clk);
		apb(addr_ctrl, 1'b1, 32'h0);
		repeat (40) @(posedge clk);
		rdc(addr_irq_status, 32'h9);
		$display("test continuous done");
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		cmp32({27'h0, hold, start, b1, b0, irq}, 32'h0);
		rdc(addr_count, 32'h0);
		rdc(addr_ctrl, 32'h0);
		$display("test mid_reset done");
		print_verdict();
	end
endmodule

//--- verification/ccd_ctrl_monitor.sv
// Checker on the converter controller's pins and APB answer.
// Assumes HOLD stays at its reset value of four cycles.
`timescale 1ns/1ps
module ccd_ctrl_monitor
	import ccd_ctrl_pkg::*;
(
	input wire logic clk,
	input wire logic reset,
	input wire logic psel,
	input wire logic penable,
	input wire logic [7:0] paddr,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic bandwidth_select_bit0,
	input wire logic bandwidth_select_bit1,
	input wire logic reference_hold,
	input wire logic start_convert
);
	logic [15:0] gap_r;
	logic [15:0] min_gap;
	logic [1:0] bw;
	assign bw = {bandwidth_select_bit1, bandwidth_select_bit0};
	assign min_gap = bw == 2'h0 ? period_bw0_cyc : bw == 2'h1 ? period_bw1_cyc :
		bw == 2'h2 ? period_bw2_cyc : period_bw3_cyc;
	// Saturates so the first start after reset is never flagged
	always_ff @(posedge clk)
	begin
		if (reset)
			gap_r <= 16'hffff;
		else if (start_convert)
			gap_r <= 16'h0001;
		else if (gap_r != 16'hffff)
			gap_r <= gap_r + 16'h0001;
	end
	////////////////////////////////////////
	default clocking @(posedge clk); endclocking
	default disable iff (reset);
	a_bw_static: assert property (!$stable(bw) |-> !reference_hold && !$past(reference_hold))
		else $error("bandwidth pins moved during a conversion");
	a_start_spacing: assert property (start_convert |-> gap_r >= min_gap)
		else $error("start edges too close");
	a_hold_settle: assert property ($rose(reference_hold) |-> !$past(reference_hold, 3))
		else $error("hold raised without settle time");
	a_hold_at_start: assert property (start_convert |-> reference_hold)
		else $error("start without held reference");
	a_start_pulse: assert property (start_convert |=> !start_convert)
		else $error("start wider than one cycle");
	a_hold_after_start: assert property (start_convert |=> reference_hold [*2])
		else $error("hold released too early");
	a_hold_release: assert property (start_convert |-> ##[3:5] !reference_hold)
		else $error("hold not released after start");
	a_apb_answer: assert property (psel && !penable |=> pready)
		else $error("no ready in access phase");
	a_ready_access: assert property (pready |-> psel && penable)
		else $error("ready outside access phase");
	a_unmapped_err: assert property (pready && paddr > 8'h1c |-> pslverr)
		else $error("unmapped access not refused");
	c_start: cover property (start_convert);
	c_slow_start: cover property (start_convert && bw == 2'h3);
	c_refused: cover property (pready && pslverr);
endmodule
bind ccd_convert_ctrl ccd_ctrl_monitor u_mon (.clk, .reset, .psel, .penable, .paddr, .pready, .pslverr,
	.bandwidth_select_bit0, .bandwidth_select_bit1, .reference_hold, .start_convert);

//--- verification/ccd_device_model.sv
// Behavioural converter: codes the held difference on each start edge.
// Assumes diff is set before the start edge and the clock runs freely.
`timescale 1ns/1ps
module ccd_device_model
(
	input wire logic clk,
	input wire logic reference_hold,
	input wire logic start_convert,
	input wire logic signed [15:0] diff,
	output logic [13:0] data_pin,
	output logic out_of_range_pin,
	output logic data_valid_pin
);
	logic [14:0] word;
	initial
	begin
		{out_of_range_pin, data_pin} = 15'h2aaa;
		data_valid_pin = 1'b0;
	end
	// Difference of held reference and video
	always @(posedge start_convert)
	begin
		if (!reference_hold)
			word = 15'h5555;
		else if (diff > 16'sh3fff)
			word = 15'h7fff;
		else if (diff < 16'sh0000)
			word = 15'h4000;
		else
			word = {1'b0, diff[13:0]};
		repeat (3) @(posedge clk);
		{out_of_range_pin, data_pin} <= word;
		repeat (3) @(posedge clk);
		data_valid_pin <= 1'b1;
		repeat (3) @(posedge clk);
		data_valid_pin <= 1'b0;
		// Lines no longer held show the inverse, not stale data
		{out_of_range_pin, data_pin} <= ~word;
	end
endmodule
